// *** design/cell_pkg.sv ***
// Shared constants and types for the configurable logic cell.
// Assumes a single 25 MHz clock and a 32-bit AHB-Lite register bus.
package cell_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_INVERT = 8'h04;
  localparam logic [7:0] OFS_SEL_LOW = 8'h08;
  localparam logic [7:0] OFS_SEL_HIGH = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // Control register fields.
  localparam int CTL_ENABLE = 7;
  localparam int CTL_PIN_OE = 6;
  localparam int CTL_OUT_VALUE = 5;
  localparam int CTL_RISE_IE = 4;
  localparam int CTL_FALL_IE = 3;
  localparam int CTL_FUNC_HI = 2;
  localparam int CTL_FUNC_LO = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hDF;

  // Polarity register fields.
  localparam int INV_OUTPUT = 7;
  localparam int INV_GATE_HI = 3;
  localparam int INV_GATE_LO = 0;
  localparam logic [7:0] INVERT_WRITE_MASK = 8'h8F;

  // Selector fields: low nibble holds one input, upper field the other.
  localparam int SEL_LO_HI = 2;
  localparam int SEL_LO_LO = 0;
  localparam int SEL_HI_HI = 6;
  localparam int SEL_HI_LO = 4;
  localparam logic [7:0] SEL_WRITE_MASK = 8'h77;

  // Base input index of each data selector; index wraps modulo 16.
  localparam logic [3:0] BASE_DATA1 = 4'h0;
  localparam logic [3:0] BASE_DATA2 = 4'h4;
  localparam logic [3:0] BASE_DATA3 = 4'h8;
  localparam logic [3:0] BASE_DATA4 = 4'hC;

  // Interrupt status bit of the cell.
  localparam int IRQ_CELL = 0;
  localparam logic [7:0] IRQ_WRITE_MASK = 8'h01;

  // AHB-Lite encodings used by the slave.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  // Logic function codes.
  typedef enum logic [2:0] {
    FN_AND_OR = 3'b000,
    FN_OR_XOR = 3'b001,
    FN_AND4 = 3'b010,
    FN_SR_LATCH = 3'b011,
    FN_DFF_SR = 3'b100,
    FN_DFF2_R = 3'b101,
    FN_JK_R = 3'b110,
    FN_LATCH_SR = 3'b111
  } function_type;

  // Input index chosen by a three-bit selector code from a base index.
  function automatic logic [3:0] select_index(input logic [2:0] code,
                                              input logic [3:0] base);
    select_index = base + {1'b0, code};
  endfunction

endpackage

// *** design/cell_func_if.sv ***
// Bundle between the cell register block and its logic function core.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/100ps
interface cell_func_if;
  import cell_pkg::*;
  logic [3:0] gate;
  function_type mode;
  logic enable;
  logic result;

  modport core (input gate, input mode, input enable, output result);
  modport ctrl (output gate, output mode, output enable, input result);
endinterface

// *** design/cell_function.sv ***
// Logic function stage: eight combinational and storage functions.
// Assumes gate values already carry their polarity; gate 1 is the clock
// of the flip-flop functions and gate 3 their reset; gate 4 is the set of codes 100 and 111, a data input of 101 and K of 110.
`timescale 1ns/100ps
module cell_function
  import cell_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Cell link
  cell_func_if.core fn
);

  logic state;
  logic g1_prev;
  logic next_state;
  wire logic g1 = fn.gate[0];
  wire logic g2 = fn.gate[1];
  wire logic g3 = fn.gate[2];
  wire logic g4 = fn.gate[3];
  wire logic g1_rise = g1 & ~g1_prev;
  wire logic sr_set = g1 | g2;
  wire logic sr_clr = g3 | g4;

  // Next storage value; resets win over sets, which win over the clock.
  always_comb begin
    next_state = state;
    unique case (fn.mode)
      // (R8) latch function
      FN_SR_LATCH: begin
        if (sr_clr) begin
          next_state = 1'b0;
        end else if (sr_set) begin
          next_state = 1'b1;
        end
      end
      // (R9) D flip-flops
      FN_DFF_SR: begin
        if (g3) begin
          next_state = 1'b0;
        end else if (g4) begin
          next_state = 1'b1;
        end else if (g1_rise) begin
          next_state = g2;
        end
      end
      FN_DFF2_R: begin
        if (g3) begin
          next_state = 1'b0;
        end else if (g1_rise) begin
          next_state = g2 & g4;
        end
      end
      // (R10) J-K flip-flop and latch
      FN_JK_R: begin
        if (g3) begin
          next_state = 1'b0;
        end else if (g1_rise) begin
          next_state = (g2 & ~state) | (~g4 & state);
        end
      end
      FN_LATCH_SR: begin
        if (g3) begin
          next_state = 1'b0;
        end else if (g4) begin
          next_state = 1'b1;
        end else if (g1) begin
          next_state = g2;
        end
      end
      FN_AND_OR, FN_OR_XOR, FN_AND4: begin
        next_state = 1'b0;
      end
    endcase
  end

  // Storage is cleared while the cell is off so it restarts clean.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= 1'b0;
      g1_prev <= 1'b0;
    end else begin
      state <= fn.enable ? next_state : 1'b0;
      g1_prev <= g1;
    end
  end

  // (R8) combinational functions; latches are transparent, so they
  // show the next value at once rather than a cycle later.
  always_comb begin
    unique case (fn.mode)
      FN_AND_OR: fn.result = (g1 & g2) | (g3 & g4);
      FN_OR_XOR: fn.result = (g1 | g2) ^ (g3 | g4);
      FN_AND4: fn.result = g1 & g2 & g3 & g4;
      FN_SR_LATCH, FN_LATCH_SR: fn.result = next_state;
      FN_DFF_SR, FN_DFF2_R, FN_JK_R: fn.result = state;
    endcase
  end

endmodule

// *** design/logic_cell_control.sv ***
// Configurable logic cell: registers, polarity, input selection,
// output, edge interrupt and AHB-Lite slave.
// Assumes gate outputs and cell inputs are synchronous to clk_in and
// that the bus master issues only single word transfers.
//
// Summary of operation
// (R1) Cell logic needs no processor clock.
// (R2) Keep fast oscillator alive if enabled, selected.
// (R3) Control bit 7 enables; disabled output zero.
// (R4) Control bit 6 drives cell onto pin.
// (R5) Control bit 5 reads final output.
// (R6) Bit 4 sets flag on rising edge.
// (R7) Bit 3 sets flag on falling edge.
// (R8) Codes 000-011: AND-OR, OR-XOR, AND4, SR latch.
// (R9) Codes 100, 101: D flip-flop variants.
// (R10) Codes 110, 111: J-K, transparent latch.
// (R11) Polarity bit 7 inverts function output.
// (R12) Polarity bits 0-3 invert gates 1-4.
// (R13) Reset clears control; selections stay.
// (R14) Software clears flag; edge wins clear.
// (R15) Input-2 codes map onto inputs 4-11.
// (R16) Edge detect works during sleep.
`timescale 1ns/100ps
module logic_cell_control
  import cell_pkg::*;
(
  // Clock and resets
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic power_on_rst_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [7:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  // Cell inputs and gate stage
  input wire logic [15:0] cell_inputs_in,
  input wire logic [3:0] gate_in,
  output logic [3:0] data_sel_out,
  // Pin, oscillator and interrupt
  output logic cell_output_value_out,
  output logic pin_out,
  output logic pin_oe_n_out,
  output logic fast_osc_keep_out,
  output logic irq_out
);

  localparam logic [3:0] OSC_INPUT_INDEX = 4'hD;

  // Any reset clears control state; power-on also clears selections.
  wire logic any_rst = sys_rst_in | power_on_rst_in;

  // Registers.
  logic [7:0] cell_control;
  // The output invert bit and the gate bits reset differently, so they
  // live in two flip-flop groups and are joined here for reads.
  logic output_invert_bit;
  logic [6:0] invert_low;
  wire logic [7:0] signal_invert_control = {output_invert_bit, invert_low};
  logic [7:0] input_select_low;
  logic [7:0] input_select_high;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic cell_out;
  logic cell_out_prev;

  // Bus data phase state.
  logic wr_pending;
  logic [7:0] wr_addr;

  // Field views of the control and polarity registers.
  wire logic cell_enable = cell_control[CTL_ENABLE];
  wire logic pin_output_enable = cell_control[CTL_PIN_OE];
  wire logic rise_irq_enable = cell_control[CTL_RISE_IE];
  wire logic fall_irq_enable = cell_control[CTL_FALL_IE];
  wire logic [2:0] function_select =
    cell_control[CTL_FUNC_HI:CTL_FUNC_LO];
  wire logic output_invert = signal_invert_control[INV_OUTPUT];
  wire logic [3:0] gate_invert =
    signal_invert_control[INV_GATE_HI:INV_GATE_LO];

  // Selector codes.
  wire logic [2:0] input1_select = input_select_low[SEL_LO_HI:SEL_LO_LO];
  wire logic [2:0] input2_select = input_select_low[SEL_HI_HI:SEL_HI_LO];
  wire logic [2:0] input3_select = input_select_high[SEL_LO_HI:SEL_LO_LO];
  wire logic [2:0] input4_select = input_select_high[SEL_HI_HI:SEL_HI_LO];

  // (R15) selector to input index
  wire logic [3:0] idx1 = select_index(input1_select, BASE_DATA1);
  wire logic [3:0] idx2 = select_index(input2_select, BASE_DATA2);
  wire logic [3:0] idx3 = select_index(input3_select, BASE_DATA3);
  wire logic [3:0] idx4 = select_index(input4_select, BASE_DATA4);
  wire logic data_in1 = cell_inputs_in[idx1];
  wire logic data_in2 = cell_inputs_in[idx2];
  wire logic data_in3 = cell_inputs_in[idx3];
  wire logic data_in4 = cell_inputs_in[idx4];

  // (R2) oscillator stays on while picked
  wire logic osc_selected = (idx1 == OSC_INPUT_INDEX) |
    (idx2 == OSC_INPUT_INDEX) | (idx3 == OSC_INPUT_INDEX) |
    (idx4 == OSC_INPUT_INDEX);
  wire logic next_osc_keep = cell_enable & osc_selected;

  // Function core link.
  cell_func_if fn ();

  // (R12) gate polarity before function
  assign fn.gate = gate_in ^ gate_invert;
  assign fn.mode = function_type'(function_select);
  assign fn.enable = cell_enable;

  // (R1) cell core on its own logic
  cell_function core (
    .clk_in(clk_in),
    .rst_in(any_rst),
    .fn(fn)
  );

  // (R11) final inversion; (R3) forced low when disabled
  wire logic next_cell_out = cell_enable & (fn.result ^ output_invert);

  // (R6) (R7) (R16) edge detectors on the output wire
  wire logic out_rise = cell_out & ~cell_out_prev;
  wire logic out_fall = ~cell_out & cell_out_prev;
  wire logic edge_event = (rise_irq_enable & out_rise) |
    (fall_irq_enable & out_fall);

  // Address phase decode: a transfer is accepted when hready is high.
  wire logic bus_take = hsel_in & hready_in &
    ((htrans_in == HTRANS_NONSEQ) | (htrans_in == HTRANS_SEQ));
  wire logic write_take = bus_take & hwrite_in;
  wire logic read_take = bus_take & ~hwrite_in;
  wire logic [7:0] wdata = hwdata_in[7:0];

  // Data phase write strobes per register.
  wire logic wr_control = wr_pending & (wr_addr == OFS_CONTROL);
  wire logic wr_invert = wr_pending & (wr_addr == OFS_INVERT);
  wire logic wr_sel_low = wr_pending & (wr_addr == OFS_SEL_LOW);
  wire logic wr_sel_high = wr_pending & (wr_addr == OFS_SEL_HIGH);
  wire logic wr_status = wr_pending & (wr_addr == OFS_IRQ_STATUS);
  wire logic wr_mask = wr_pending & (wr_addr == OFS_IRQ_MASK);

  // (R5) live output shows in control bit 5
  logic [7:0] control_view;
  always_comb begin
    control_view = cell_control;
    control_view[CTL_OUT_VALUE] = cell_out;
  end

  // Read mux; unmapped offsets read zero.
  logic [7:0] read_byte;
  always_comb begin
    unique case (haddr_in)
      OFS_CONTROL: read_byte = control_view;
      OFS_INVERT: read_byte = signal_invert_control;
      OFS_SEL_LOW: read_byte = input_select_low;
      OFS_SEL_HIGH: read_byte = input_select_high;
      OFS_IRQ_STATUS: read_byte = irq_status;
      OFS_IRQ_MASK: read_byte = irq_mask;
      default: read_byte = 8'h00;
    endcase
  end

  // (R14) set wins over write-one-to-clear
  wire logic [7:0] status_clear = wr_status ? (wdata & IRQ_WRITE_MASK) :
    8'h00;
  wire logic [7:0] status_set = {7'h00, edge_event};
  wire logic [7:0] next_irq_status = (irq_status & ~status_clear) |
    status_set;

  // Bus slave: zero wait states, always OKAY.
  always_ff @(posedge clk_in or posedge any_rst) begin
    if (any_rst) begin
      wr_pending <= 1'b0;
      wr_addr <= 8'h00;
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b0;
      hresp_out <= 1'b0;
    end else begin
      wr_pending <= write_take;
      wr_addr <= haddr_in;
      hreadyout_out <= 1'b1;
      if (read_take) begin
        hrdata_out <= {24'h00_0000, read_byte};
      end
    end
  end

  // (R3) (R4) (R13) control clears on any reset
  always_ff @(posedge clk_in or posedge any_rst) begin
    if (any_rst) begin
      cell_control <= CONTROL_RESET;
      output_invert_bit <= 1'b0;
    end else begin
      if (wr_control) begin
        cell_control <= wdata & CONTROL_WRITE_MASK;
      end
      if (wr_invert) begin
        output_invert_bit <= wdata[INV_OUTPUT];
      end
    end
  end

  // (R13) selections survive a system reset; only power-on clears them.
  always_ff @(posedge clk_in or posedge power_on_rst_in) begin
    if (power_on_rst_in) begin
      invert_low <= 7'h00;
      input_select_low <= 8'h00;
      input_select_high <= 8'h00;
    end else begin
      if (wr_invert) begin
        invert_low <= wdata[6:0] & INVERT_WRITE_MASK[6:0];
      end
      if (wr_sel_low) begin
        input_select_low <= wdata & SEL_WRITE_MASK;
      end
      if (wr_sel_high) begin
        input_select_high <= wdata & SEL_WRITE_MASK;
      end
    end
  end

  // Interrupt status, mask and output.
  always_ff @(posedge clk_in or posedge any_rst) begin
    if (any_rst) begin
      irq_status <= 8'h00;
      irq_mask <= 8'h00;
      irq_out <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      if (wr_mask) begin
        irq_mask <= wdata & IRQ_WRITE_MASK;
      end
      irq_out <= |(next_irq_status & irq_mask);
    end
  end

  // Cell output wire, pin and selector outputs, all registered.
  always_ff @(posedge clk_in or posedge any_rst) begin
    if (any_rst) begin
      cell_out <= 1'b0;
      cell_out_prev <= 1'b0;
      cell_output_value_out <= 1'b0;
      pin_out <= 1'b0;
      pin_oe_n_out <= 1'b1;
      fast_osc_keep_out <= 1'b0;
      data_sel_out <= 4'h0;
    end else begin
      cell_out <= next_cell_out;
      cell_out_prev <= cell_out;
      cell_output_value_out <= next_cell_out;
      // (R4) pin driven only when gated on
      pin_out <= next_cell_out & pin_output_enable;
      pin_oe_n_out <= ~pin_output_enable;
      fast_osc_keep_out <= next_osc_keep;
      data_sel_out <= {data_in4, data_in3, data_in2, data_in1};
    end
  end

endmodule

// *** verif/cell_monitor.sv ***
// Concurrent checks on the logic cell top ports.
// Assumes one clock and a single AHB-Lite master on the bus.
`timescale 1ns/100ps
module cell_monitor (
  // Clock and resets
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic power_on_rst_in,
  // Bus
  input wire logic hsel_in,
  input wire logic [7:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic hresp_out,
  input wire logic [31:0] hrdata_out,
  // Cell
  input wire logic cell_output_value_out,
  input wire logic pin_out,
  input wire logic pin_oe_n_out,
  input wire logic irq_out
);
  logic taken;
  logic wr_irq;
  logic out_q;
  logic [3:0] irq_wr;
  logic [2:0] edge_h;
  // A transfer is taken with select, ready and NONSEQ or SEQ.
  assign taken = hsel_in && hready_in && htrans_in[1];
  assign wr_irq = taken && hwrite_in && haddr_in[4];
  // Recent irq writes and output edges; the request lags both a little.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_wr <= 4'h0;
      edge_h <= 3'h0;
      out_q <= 1'b0;
    end else begin
      irq_wr <= {irq_wr[2:0], wr_irq};
      edge_h <= {edge_h[1:0], out_q != cell_output_value_out};
      out_q <= cell_output_value_out;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in || power_on_rst_in);
  AST_OKAY: assert property (hresp_out == 1'b0)
    else $error("bus response not OKAY");
  AST_UPPER: assert property (hrdata_out[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_HOLD: assert property (
    !$past(taken && !hwrite_in) |-> $stable(hrdata_out))
    else $error("read data moved without a read");
  AST_READBACK: assert property (
    taken && !hwrite_in && haddr_in == 8'h00
    |=> hrdata_out[5] == $past(cell_output_value_out))
    else $error("control bit 5 differs from cell output");
  AST_PIN_DRIVE: assert property (
    !pin_oe_n_out |-> pin_out == cell_output_value_out)
    else $error("driven pin differs from cell output");
  AST_PIN_IDLE: assert property (pin_oe_n_out |-> !pin_out)
    else $error("pin high while not driven");
  AST_IRQ_CLEAR: assert property ($fell(irq_out) |-> irq_wr != 4'h0)
    else $error("interrupt dropped without a clear");
  AST_IRQ_CAUSE: assert property (
    $rose(irq_out) |-> edge_h != 3'h0 || irq_wr != 4'h0)
    else $error("interrupt raised without an output edge");
  COV_READ: cover property (taken && !hwrite_in && haddr_in == 8'h00);
  COV_IRQ: cover property ($rose(irq_out));
  COV_PIN: cover property (!pin_oe_n_out && pin_out);
endmodule

bind logic_cell_control cell_monitor mon (.clk_in, .sys_rst_in,
  .power_on_rst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
  .hready_in, .hresp_out, .hrdata_out, .cell_output_value_out,
  .pin_out, .pin_oe_n_out, .irq_out);

// *** verif/testbench.sv ***
// Self-checking bench for the logic cell through its AHB-Lite slave.
// Assumes the package, design and monitor are compiled first.
`timescale 1ns/100ps
module testbench;
  import cell_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic power_on_rst_in = 1'b1;
  logic hsel_in = 1'b0;
  logic [7:0] haddr_in = 8'h00;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [31:0] hwdata_in = 32'h0;
  logic [15:0] cell_inputs_in = 16'h0;
  logic [3:0] gate_in = 4'h0;
  logic hready_in, hreadyout_out, hresp_out, pin_out, pin_oe_n_out;
  logic cell_output_value_out, fast_osc_keep_out, irq_out, q;
  logic [31:0] hrdata_out, rd;
  logic [3:0] data_sel_out, p;
  int fails = 0;
  int n_compared = 0;
  const logic [3:0] vec [9] = '{4'h2, 4'h3, 4'h0, 4'hA, 4'hB, 4'h4,
    4'h8, 4'h1, 4'h0};
  // The one slave's ready is the bus ready.
  assign hready_in = hreadyout_out;
  always #20 clk_in = ~clk_in;
  logic_cell_control uut (.clk_in, .sys_rst_in, .power_on_rst_in,
    .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in(3'h2),
    .hwdata_in, .hready_in, .hreadyout_out, .hresp_out, .hrdata_out,
    .cell_inputs_in, .gate_in, .data_sel_out, .cell_output_value_out,
    .pin_out, .pin_oe_n_out, .fast_osc_keep_out, .irq_out);
  task automatic wrap_up;
    $display("mismatches %0d of %0d checks", fails, n_compared);
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // Waits for ready at an edge; a bounded wait so a hang ends the run.
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) begin
      n++;
      if (n > 50) begin
        fails++;
        wrap_up();
      end
      @(posedge clk_in);
    end
  endtask
  // One single-word transfer; read data is taken at the data edge.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel_in <= 1'b1;
    haddr_in <= a;
    hwrite_in <= wr;
    htrans_in <= HTRANS_NONSEQ;
    wait_ready();
    htrans_in <= 2'h0;
    hwdata_in <= d;
    wait_ready();
    rd = hrdata_out;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Step-level reference of the eight functions; latches held per step.
  function automatic logic model(input logic [2:0] m, input logic [3:0] g,
                                 input logic [3:0] pg, input logic qi);
    logic ck;
    ck = g[0] && !pg[0];
    case (m)
      3'h0: model = (g[0] & g[1]) | (g[2] & g[3]);
      3'h1: model = (g[0] | g[1]) ^ (g[2] | g[3]);
      3'h2: model = &g;
      3'h3: model = (g[2] | g[3]) ? 1'b0 : (g[0] | g[1]) ? 1'b1 : qi;
      3'h4: model = g[2] ? 1'b0 : g[3] ? 1'b1 : ck ? g[1] : qi;
      3'h5: model = g[2] ? 1'b0 : ck ? (g[1] & g[3]) : qi;
      3'h6: model = g[2] ? 1'b0 : ck ? (g[1] & !qi | !g[3] & qi) : qi;
      default: model = g[2] ? 1'b0 : g[3] ? 1'b1 : g[0] ? g[1] : qi;
    endcase
  endfunction
  // Main sequence.
  initial begin
    tick(4);
    sys_rst_in <= 1'b0;
    power_on_rst_in <= 1'b0;
    tick(2);
    bus(1, OFS_CONTROL, 32'h20);
    bus(0, OFS_CONTROL, 32'h0);
    check("control", rd, 32'h0);
    bus(1, 8'h1C, 32'hFF);
    bus(0, 8'h1C, 32'h0);
    check("unmapped", rd, 32'h0);
    gate_in <= 4'hF;
    bus(1, OFS_CONTROL, 32'hC2);
    tick(3);
    bus(0, OFS_CONTROL, 32'h0);
    check("control", rd, 32'hE2);
    check("pin", {30'h0, pin_oe_n_out, pin_out}, 32'h1);
    bus(1, OFS_INVERT, 32'h1);
    tick(3);
    check("gate1 inverted", {31'h0, cell_output_value_out}, 32'h0);
    bus(1, OFS_INVERT, 32'hFF);
    bus(0, OFS_INVERT, 32'h0);
    check("invert", rd, 32'h8F);
    check("out inverted", {31'h0, cell_output_value_out}, 32'h1);
    bus(1, OFS_INVERT, 32'h0);
    bus(1, OFS_CONTROL, 32'h42);
    tick(3);
    check("off", {30'h0, pin_oe_n_out, cell_output_value_out}, 32'h0);
    bus(1, OFS_CONTROL, 32'h02);
    tick(3);
    check("pin off", {31'h0, pin_oe_n_out}, 32'h1);
    for (int m = 0; m < 8; m++) begin
      gate_in <= 4'h0;
      bus(1, OFS_CONTROL, 32'h0);
      bus(1, OFS_CONTROL, 32'h80 | 32'(m));
      q = 1'b0;
      p = 4'h0;
      foreach (vec[i]) begin
        gate_in <= vec[i];
        tick(3);
        q = model(3'(m), vec[i], p, q);
        p = vec[i];
        check("function", {31'h0, cell_output_value_out},
              {31'h0, q});
      end
    end
    // input-2 codes onto inputs 4 to 11.
    for (int k = 0; k < 8; k++) begin
      bus(1, OFS_SEL_LOW, 32'(k) << 4);
      cell_inputs_in <= 16'h1 << (k + 4);
      tick(3);
      check("data 2", {31'h0, data_sel_out[1]}, 32'h1);
      cell_inputs_in <= ~(16'h1 << (k + 4));
      tick(3);
      check("data 2", {31'h0, data_sel_out[1]}, 32'h0);
    end
    // oscillator kept while enabled and picked.
    bus(1, OFS_SEL_HIGH, 32'h05);
    bus(1, OFS_CONTROL, 32'h80);
    tick(2);
    check("osc keep", {31'h0, fast_osc_keep_out}, 32'h1);
    bus(1, OFS_CONTROL, 32'h0);
    tick(2);
    check("osc keep", {31'h0, fast_osc_keep_out}, 32'h0);
    gate_in <= 4'h0;
    bus(1, OFS_IRQ_MASK, 32'h1);
    bus(1, OFS_CONTROL, 32'h8A);
    gate_in <= 4'hF;
    tick(4);
    check("irq", {31'h0, irq_out}, 32'h0);
    gate_in <= 4'h0;
    tick(4);
    check("irq", {31'h0, irq_out}, 32'h1);
    bus(1, OFS_IRQ_STATUS, 32'h1);
    tick(3);
    check("irq", {31'h0, irq_out}, 32'h0);
    bus(1, OFS_CONTROL, 32'h92);
    gate_in <= 4'hF;
    tick(4);
    check("irq", {31'h0, irq_out}, 32'h1);
    bus(1, OFS_IRQ_MASK, 32'h0);
    tick(3);
    check("irq", {31'h0, irq_out}, 32'h0);
    bus(0, OFS_IRQ_STATUS, 32'h0);
    check("status", rd, 32'h1);
    bus(1, OFS_IRQ_STATUS, 32'h1);
    gate_in <= 4'h0;
    tick(4);
    bus(0, OFS_IRQ_STATUS, 32'h0);
    check("status", rd, 32'h0);
    bus(1, OFS_SEL_LOW, 32'h35);
    bus(1, OFS_CONTROL, 32'hC2);
    sys_rst_in <= 1'b1;
    tick(2);
    check("reset pins", {30'h0, pin_oe_n_out, irq_out}, 32'h2);
    sys_rst_in <= 1'b0;
    tick(2);
    bus(0, OFS_CONTROL, 32'h0);
    check("control", rd, 32'h0);
    bus(0, OFS_SEL_LOW, 32'h0);
    check("select", rd, 32'h35);
    wrap_up();
  end
endmodule
